// >>> dv/rcr_far_end.sv
`default_nettype none
module rcr_far_end #(
   parameter int PD_CYC = 10000            // 200 us at 50 MHz
) (
   input  wire logic       clk,            // bench clock
   input  wire logic [3:0] present,        // termination attached
   input  wire logic       pdReq,          // start a powerdown pulse
   output logic      [3:0] termSense,      // sensed termination
   output logic            powerdownPin    // system powerdown drive
);
   timeunit 1ns;
   timeprecision 1ns;
   int pdCountReg = 0;
   // a real load stays attached between probes, so no idle pattern
   assign termSense = present;
   always @(posedge clk) begin
      if (pdReq) begin
         pdCountReg <= PD_CYC;
      end else if (pdCountReg != 0) begin
         pdCountReg <= pdCountReg - 1;
      end
   end
   assign powerdownPin = (pdCountReg != 0);
endmodule
`default_nettype wire

// >>> dv/redriver_config_rxdetect_tb.sv
`default_nettype none
module redriver_config_rxdetect_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [2:0]  boostStrapHigh = 3'h4;
   logic [2:0]  boostStrapLow = 3'h4;
   logic [2:0]  gainStrap = 3'h4;
   logic [2:0]  detectStrap = 3'h4;
   logic        selectPin = 1'b0;
   logic [3:0]  present = 4'h0;
   logic        pdReq = 1'b0;
   logic [3:0]  termSense;
   logic        powerdownPin;
   logic [3:0]  address = 4'h0;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [11:0] gainCodes;
   logic [47:0] boostCodes;
   logic [3:0]  termOn;
   logic [3:0]  probeOn;
   logic        standby;
   logic [31:0] q;
   int          fails = 0;
   int          n_compared = 0;
   int          i;

   always #10 clk = ~clk;

   rcr_top dut (.clk, .rst, .boostStrapHigh, .boostStrapLow, .gainStrap,
      .detectStrap, .powerdownPin, .selectPin, .termSense, .address, .read,
      .write, .writedata, .readdata, .waitrequest, .gainCodes, .boostCodes,
      .termOn, .probeOn, .standby);
   rcr_far_end far (.clk, .present, .pdReq, .termSense, .powerdownPin);

   task automatic check(input string what, input logic [47:0] exp,
                        input logic [47:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge clk);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0);
      r = readdata;
      read <= 1'b0;
      write <= 1'b0;
      check("wait cycles", 48'd2, 48'(n));
   endtask

   task automatic power_up(input logic [2:0] g, dt, hi, lo);
      @(posedge clk);
      rst <= 1'b1;
      gainStrap <= g;
      detectStrap <= dt;
      boostStrapHigh <= hi;
      boostStrapLow <= lo;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
   endtask

   task automatic t_strap;
      logic [2:0] gtab [5] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h5};
      int k;
      for (k = 0; k < 6; k++) begin
         // pass 3 uses the reserved detect level, which acts as level 0
         power_up(3'(k % 5), (k == 3) ? 3'h3 : 3'h0, 3'((14 + k) / 5),
                  3'((14 + k) % 5));
         check("gainCodes", {4{gtab[k % 5]}}, gainCodes);
         check("boostCodes", {4{4'(10 + k), 3'(2 + k), 4'hf, 1'b0}},
               boostCodes);
         check("termOn", 4'hf, termOn);
         check("probeOn", 4'h0, probeOn);
      end
      gainStrap <= 3'h3;
      boostStrapHigh <= 3'h0;
      repeat (5) @(posedge clk);
      check("gainCodes", 12'h0, gainCodes);
      check("boostCodes", {4{4'hf, 3'h7, 4'hf, 1'b0}}, boostCodes);
   endtask

   task automatic t_bus;
      power_up(3'h3, 3'h0, 3'h0, 3'h0);
      bus(1'b1, 4'h0, 32'h1, q);
      bus(1'b1, 4'hc, 32'hfac, q);
      bus(1'b0, 4'hc, 32'h0, q);
      check("gain reg", 32'hfac, q);
      check("gainCodes", 12'hfac, gainCodes);
      bus(1'b0, 4'h2, 32'h0, q);
      check("unmapped read", 32'h0, q);
      bus(1'b1, 4'h0, 32'h0, q);
      repeat (2) @(posedge clk);
      check("gainCodes", 12'hfff, gainCodes);
   endtask

   task automatic t_float;
      int gap;
      present <= 4'b0011;
      power_up(3'h4, 3'h4, 3'h4, 3'h4);
      check("probeOn", 4'hf, probeOn);
      for (i = 0; i < 200 && termOn !== 4'b0011; i++) @(posedge clk);
      check("termOn", 4'b0011, termOn);
      for (i = 0; i < 200 && probeOn[2] !== 1'b0; i++) @(posedge clk);
      for (gap = 0; gap < 9000 && probeOn[2] !== 1'b1; gap++) @(posedge clk);
      check("retry gap ok", 1'b1, 1'(gap > 7400 && gap < 7600));
      present <= 4'b0111;
      for (i = 0; i < 300 && termOn !== 4'b0111; i++) @(posedge clk);
      check("termOn", 4'b0111, termOn);
      bus(1'b0, 4'h4, 32'h0, q);
      check("status", 32'h7, q);
   endtask

   task automatic t_retrig;
      bus(1'b1, 4'h8, 32'h1, q);
      for (i = 0; i < 10 && probeOn !== 4'b0001; i++) @(posedge clk);
      check("probeOn", 4'b0001, probeOn);
      check("termOn other", 2'b11, termOn[2:1]);
      for (i = 0; i < 300 && termOn[0] !== 1'b1; i++) @(posedge clk);
      check("termOn", 3'b111, termOn[2:0]);
   endtask

   task automatic t_pins;
      selectPin <= !selectPin;
      for (i = 0; i < 10 && probeOn !== 4'hf; i++) @(posedge clk);
      check("probeOn select", 4'hf, probeOn);
      repeat (200) @(posedge clk);
      pdReq <= 1'b1;
      @(posedge clk);
      pdReq <= 1'b0;
      repeat (6) @(posedge clk);
      check("standby", 1'b1, standby);
      check("termOn pd", 4'h0, termOn);
      check("probeOn pd", 4'h0, probeOn);
      for (i = 0; i < 11000 && powerdownPin !== 1'b0; i++) @(posedge clk);
      for (i = 0; i < 10 && probeOn !== 4'hf; i++) @(posedge clk);
      check("probeOn after pd", 4'hf, probeOn);
      check("standby", 1'b0, standby);
   endtask

   task automatic t_count(input logic [2:0] lvl, input int need);
      int n;
      logic prev;
      present <= 4'hf;
      power_up(3'h4, lvl, 3'h4, 3'h4);
      n = 0;
      prev = probeOn[0];
      for (i = 0; i < 30000 && termOn[0] !== 1'b1; i++) begin
         @(posedge clk);
         if (prev === 1'b1 && probeOn[0] === 1'b0) n++;
         prev = probeOn[0];
      end
      check("probes before detect", 48'(need), 48'(n));
   endtask

   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge clk);
      check("reset gainCodes", 12'hb6d, gainCodes);
      check("reset waitrequest", 1'b1, waitrequest);
      check("reset termOn", 4'h0, termOn);
      rst <= 1'b0;
      t_strap();
      t_bus();
      t_float();
      t_retrig();
      t_pins();
      t_count(3'h1, 3);
      t_count(3'h2, 2);
      wrap_up();
   end

   // whole run needs roughly 41k cycles
   initial begin
      repeat (100000) @(posedge clk);
      fails++;
      wrap_up();
   end
endmodule
`default_nettype wire

// >>> include/rcr_pkg.sv
`default_nettype none
package rcr_pkg;
   localparam int NUM_CH = 4;
   localparam int CLK_HZ = 50_000_000;

   // five-level strap codes
   localparam logic [2:0] LVL0 = 3'h0;
   localparam logic [2:0] LVL1 = 3'h1;
   localparam logic [2:0] LVL2 = 3'h2;
   localparam logic [2:0] LVL3 = 3'h3;
   localparam logic [2:0] LVL4 = 3'h4;

   // gain codes per strap level
   localparam logic [2:0] GAIN_L0 = 3'h0;
   localparam logic [2:0] GAIN_L1 = 3'h1;
   localparam logic [2:0] GAIN_L2 = 3'h3;
   localparam logic [2:0] GAIN_L3 = 3'h7;
   localparam logic [2:0] GAIN_L4 = 3'h5;

   // detect timing
   localparam int POLL_US = 150;
   localparam int POLL_CYC = POLL_US * (CLK_HZ / 1_000_000);
   localparam int PROBE_CYC = 64;
   localparam logic [2:0] NEED_L1 = 3'h3;
   localparam logic [2:0] NEED_L2 = 3'h2;
   localparam logic [2:0] NEED_L4 = 3'h1;

   // register offsets (byte addresses, word aligned)
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_RETRIG = 4'h8;
   localparam logic [3:0] REG_GAIN   = 4'hc;
   localparam logic [3:0] REG_BOOST  = 4'h0 + 4'h0;
   localparam logic CTRL_RESET = 1'b0;

   typedef struct packed {
      logic [3:0] firstBoostCode;
      logic [2:0] secondBoostCode;
      logic [3:0] boostShapeCode;
      logic       firstBoostSkip;
   } rcr_boost_type;

   typedef struct packed {
      logic [2:0] boostHigh;
      logic [2:0] boostLow;
      logic [2:0] gain;
      logic [2:0] detect;
   } rcr_strap_type;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_PROBE = 4'b0010,
      ST_WAIT  = 4'b0100,
      ST_DONE  = 4'b1000
   } rcr_det_type;
endpackage
`default_nettype wire

// >>> rtl/rcr_top.sv
// Notes on behaviour
// - strap mode: gain strap sets one gain for all four channels
// - bus mode: each channel holds its own gain code
// - gain strap levels 0..4 give codes 0,1,3,7,5; floating gives 5
// - gain strap only matters in strap mode
// - detect starts at power-up, powerdown/select event, or bus write
// - power-up or pin event starts detection on all channels
// - a bus write can restart detection on one channel
// - detect strap level 0 disables detection; plain buffer
// - detect strap level 1 needs three consecutive detections
// - detect strap level 2 needs two consecutive; level 3 reserved
// - floating detect strap retries about every 150 us
// - impedance high-Z until detect succeeds, then 50 ohm; detect strap level 0 or 3 gives 50 ohm once straps are captured
// - powerdown high resets channels and forces high-Z
// - straps sampled once after power-up, later changes ignored
// - strap mode: both boost straps pick one index for all
// - powerdown high places device in standby
`default_nettype none
module rcr_top (
   input  wire logic        clk,               // 50 MHz
   input  wire logic        rst,               // async, high
   input  wire logic [2:0]  boostStrapHigh,    // five-level code
   input  wire logic [2:0]  boostStrapLow,     // five-level code
   input  wire logic [2:0]  gainStrap,         // five-level code
   input  wire logic [2:0]  detectStrap,       // five-level code
   input  wire logic        powerdownPin,      // async pin
   input  wire logic        selectPin,         // async pin
   input  wire logic [3:0]  termSense,         // far-end seen, async
   input  wire logic [3:0]  address,           // avalon byte address
   input  wire logic        read,              // avalon read
   input  wire logic        write,             // avalon write
   input  wire logic [31:0] writedata,         // avalon write data
   output logic      [31:0] readdata,          // avalon read data
   output logic             waitrequest,       // avalon wait
   output logic      [11:0] gainCodes,         // 3 bits per channel
   output logic      [47:0] boostCodes,        // 12 bits per channel
   output logic      [3:0]  termOn,            // 1 = 50 ohm
   output logic      [3:0]  probeOn,           // detect pulse active
   output logic             standby            // low-power state
);
   localparam int PW = $clog2(rcr_pkg::POLL_CYC + 1);

   function automatic logic [2:0] gainMap(input logic [2:0] lvl);
      unique case (lvl)
         rcr_pkg::LVL0: gainMap = rcr_pkg::GAIN_L0;
         rcr_pkg::LVL1: gainMap = rcr_pkg::GAIN_L1;
         rcr_pkg::LVL2: gainMap = rcr_pkg::GAIN_L2;
         rcr_pkg::LVL3: gainMap = rcr_pkg::GAIN_L3;
         default:       gainMap = rcr_pkg::GAIN_L4;
      endcase
   endfunction

   function automatic logic [11:0] boostMap(input logic [4:0] idx);
      logic [3:0] s1;
      logic [2:0] s2;
      logic [3:0] pr;
      logic       by;
      s1 = 4'h0;
      s2 = 3'h0;
      pr = 4'h0;
      by = 1'b0;
      unique case (idx)
         5'h00: begin s1 = 4'h0; by = 1'b1; end
         5'h01: begin s1 = 4'h1; by = 1'b1; end
         5'h02: begin s1 = 4'h3; by = 1'b1; end
         5'h03: begin s1 = 4'h7; by = 1'b1; end
         5'h04: begin s1 = 4'h7; s2 = 3'h1; by = 1'b1; end
         5'h05: begin s1 = 4'h0; pr = 4'h1; end
         5'h06: begin s1 = 4'h1; pr = 4'h1; end
         5'h07: begin s1 = 4'h2; pr = 4'h1; end
         5'h08: begin s1 = 4'h3; pr = 4'h3; end
         5'h09: begin s1 = 4'h4; pr = 4'h3; end
         5'h0a: begin s1 = 4'h5; s2 = 3'h1; pr = 4'h7; end
         5'h0b: begin s1 = 4'h6; s2 = 3'h1; pr = 4'h7; end
         5'h0c: begin s1 = 4'h8; s2 = 3'h1; pr = 4'h7; end
         5'h0d: begin s1 = 4'ha; s2 = 3'h1; pr = 4'h7; end
         5'h0e: begin s1 = 4'ha; s2 = 3'h2; pr = 4'hf; end
         5'h0f: begin s1 = 4'hb; s2 = 3'h3; pr = 4'hf; end
         5'h10: begin s1 = 4'hc; s2 = 3'h4; pr = 4'hf; end
         5'h11: begin s1 = 4'hd; s2 = 3'h5; pr = 4'hf; end
         5'h12: begin s1 = 4'he; s2 = 3'h6; pr = 4'hf; end
         default: begin s1 = 4'hf; s2 = 3'h7; pr = 4'hf; end
      endcase
      boostMap = {s1, s2, pr, by};
   endfunction

   // pin synchronisers; straps ride along, they are read only once
   logic [17:0] syncA_reg, syncB_reg;
   logic       pdLast_reg, selLast_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         syncA_reg   <= 18'h00000;
         syncB_reg   <= 18'h00000;
         pdLast_reg  <= 1'b0;
         selLast_reg <= 1'b0;
      end else begin
         syncA_reg   <= {boostStrapHigh, boostStrapLow, gainStrap,
                         detectStrap, selectPin, powerdownPin, termSense};
         syncB_reg   <= syncA_reg;
         pdLast_reg  <= syncB_reg[4];
         selLast_reg <= syncB_reg[5];
      end
   end
   logic       pdSync, pinEvent;
   logic [3:0] senseSync;
   assign pdSync    = syncB_reg[4];
   assign senseSync = syncB_reg[3:0];
   assign pinEvent  = (pdLast_reg & ~pdSync) | (selLast_reg ^ syncB_reg[5]);

   // strap capture once after reset release
   rcr_pkg::rcr_strap_type strap_reg, strap_next;
   logic                   captured_reg, captured_next;
   logic [1:0]             warm_reg, warm_next;
   always_comb begin
      strap_next    = strap_reg;
      warm_next     = {warm_reg[0], 1'b1};
      captured_next = captured_reg | warm_reg[1];
      if (warm_reg[1] && !captured_reg)
         strap_next = rcr_pkg::rcr_strap_type'(syncB_reg[17:6]);
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strap_reg    <= '0;
         captured_reg <= 1'b0;
         warm_reg     <= 2'h0;
      end else begin
         strap_reg    <= strap_next;
         captured_reg <= captured_next;
         warm_reg     <= warm_next;
      end
   end

   // bus registers: ctrl bit0 = bus mode, status = termOn, retrig, gains
   logic        busMode_reg, busMode_next;
   logic [11:0] gainBus_reg, gainBus_next;
   logic [3:0]  retrig_reg, retrig_next;
   logic [31:0] readdata_next;
   logic        waitrequest_next;
   logic        access;
   assign access = (read | write) & waitrequest;
   always_comb begin
      busMode_next     = busMode_reg;
      gainBus_next     = gainBus_reg;
      retrig_next      = 4'h0;
      readdata_next    = readdata;
      waitrequest_next = 1'b1;
      if (access) begin
         waitrequest_next = 1'b0;
         readdata_next    = 32'h0;
         if (read) begin
            unique case (address)
               rcr_pkg::REG_CTRL:   readdata_next = {31'h0, busMode_reg};
               rcr_pkg::REG_STATUS: readdata_next = {28'h0, termOn};
               rcr_pkg::REG_GAIN:   readdata_next = {20'h0, gainBus_reg};
               default:             readdata_next = 32'h0;
            endcase
         end
      end
      // a write lands only on the edge where the master sees the answer
      if (write && !waitrequest) begin
         unique case (address)
            rcr_pkg::REG_CTRL:   busMode_next = writedata[0];
            rcr_pkg::REG_RETRIG: retrig_next = writedata[3:0];
            rcr_pkg::REG_GAIN:   gainBus_next = writedata[11:0];
            default: ;
         endcase
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busMode_reg <= rcr_pkg::CTRL_RESET;
         gainBus_reg <= {4{rcr_pkg::GAIN_L4}};
         retrig_reg  <= 4'h0;
         readdata    <= 32'h0;
         waitrequest <= 1'b1;
      end else begin
         busMode_reg <= busMode_next;
         gainBus_reg <= gainBus_next;
         retrig_reg  <= retrig_next;
         readdata    <= readdata_next;
         waitrequest <= waitrequest_next;
      end
   end

   // gain and boost decode
   logic [11:0] gainCodes_next;
   logic [47:0] boostCodes_next;
   logic [4:0]  boostIdx;
   logic        standby_next;
   assign boostIdx = 5'(strap_reg.boostHigh) * 5'h5 + 5'(strap_reg.boostLow);
   always_comb begin
      if (busMode_reg)
         gainCodes_next = gainBus_reg;
      else
         gainCodes_next = {4{gainMap(strap_reg.gain)}};
      boostCodes_next = {4{boostMap(boostIdx)}};
      standby_next    = pdSync;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gainCodes  <= {4{rcr_pkg::GAIN_L4}};
         boostCodes <= 48'h0;
         standby    <= 1'b0;
      end else begin
         gainCodes  <= gainCodes_next;
         boostCodes <= boostCodes_next;
         standby    <= standby_next;
      end
   end

   // per-channel detect machines
   logic [2:0] need;
   logic       detEnable;
   logic       kickAll;
   logic       kickAll_reg;
   always_comb begin
      unique case (strap_reg.detect)
         rcr_pkg::LVL1: need = rcr_pkg::NEED_L1;
         rcr_pkg::LVL2: need = rcr_pkg::NEED_L2;
         default:       need = rcr_pkg::NEED_L4;
      endcase
   end
   // level 3 reserved: treated as no detection, like level 0
   assign detEnable = (strap_reg.detect != rcr_pkg::LVL0) &&
                      (strap_reg.detect != rcr_pkg::LVL3);
   // first cycle after strap capture is the power-up trigger
   assign kickAll = pinEvent | kickAll_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         kickAll_reg <= 1'b0;
      else
         kickAll_reg <= warm_reg[1] & ~captured_reg;
   end

   wire logic [3:0] termNext, probeNext;
   genvar c;
   generate
      for (c = 0; c < rcr_pkg::NUM_CH; c++) begin : g_ch
         rcr_pkg::rcr_det_type st_reg, st_next;
         logic [PW-1:0] cnt_reg, cnt_next;
         logic [2:0]    hits_reg, hits_next;
         logic          term_next, probe_next;
         always_comb begin
            st_next    = st_reg;
            cnt_next   = cnt_reg;
            hits_next  = hits_reg;
            unique case (st_reg)
               rcr_pkg::ST_IDLE: ;
               rcr_pkg::ST_PROBE: begin
                  cnt_next = cnt_reg - PW'(1);
                  if (cnt_reg == '0) begin
                     if (senseSync[c] && hits_reg + 3'h1 >= need)
                        st_next = rcr_pkg::ST_DONE;
                     else begin
                        hits_next = senseSync[c] ? hits_reg + 3'h1 : 3'h0;
                        st_next   = rcr_pkg::ST_WAIT;
                        cnt_next  = PW'(rcr_pkg::POLL_CYC - 1);
                     end
                  end
               end
               rcr_pkg::ST_WAIT: begin
                  cnt_next = cnt_reg - PW'(1);
                  if (cnt_reg == '0) begin
                     st_next  = rcr_pkg::ST_PROBE;
                     cnt_next = PW'(rcr_pkg::PROBE_CYC - 1);
                  end
               end
               rcr_pkg::ST_DONE: ;
            endcase
            if ((kickAll | retrig_reg[c]) && detEnable) begin
               st_next   = rcr_pkg::ST_PROBE;
               cnt_next  = PW'(rcr_pkg::PROBE_CYC - 1);
               hits_next = 3'h0;
            end
            if (pdSync || !detEnable) begin
               st_next   = rcr_pkg::ST_IDLE;
               hits_next = 3'h0;
            end
            term_next  = (st_next == rcr_pkg::ST_DONE) |
                         (!detEnable & !pdSync & captured_reg);
            probe_next = (st_next == rcr_pkg::ST_PROBE);
         end
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               st_reg     <= rcr_pkg::ST_IDLE;
               cnt_reg    <= '0;
               hits_reg   <= 3'h0;
            end else begin
               st_reg     <= st_next;
               cnt_reg    <= cnt_next;
               hits_reg   <= hits_next;
            end
         end
         assign termNext[c]  = term_next;
         assign probeNext[c] = probe_next;
         a_pd_hiz: assert property (@(posedge clk) disable iff (rst)
            pdSync |=> !termOn[c])
            else $error("termination on during powerdown");
         a_term_done: assert property (@(posedge clk) disable iff (rst)
            $rose(termOn[c]) && detEnable |-> st_reg == rcr_pkg::ST_DONE)
            else $error("termination on before detect done");
         a_probe_hiz: assert property (@(posedge clk) disable iff (rst)
            probeOn[c] |-> !termOn[c])
            else $error("termination on while probing");
         a_buffer_term: assert property (@(posedge clk) disable iff (rst)
            captured_reg && !detEnable && !pdSync |=> termOn[c])
            else $error("buffer mode without termination");
      end
   endgenerate
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         termOn  <= 4'h0;
         probeOn <= 4'h0;
      end else begin
         termOn  <= termNext;
         probeOn <= probeNext;
      end
   end

   a_gain_strap: assert property (@(posedge clk) disable iff (rst)
      !busMode_reg && captured_reg |=>
      gainCodes[2:0] == gainMap(strap_reg.gain))
      else $error("strap gain code wrong");
   a_strap_hold: assert property (@(posedge clk) disable iff (rst)
      captured_reg |=> $stable(strap_reg))
      else $error("strap changed after capture");
endmodule
`default_nettype wire
